// *** src/hww_ctrl.sv ***
// Halt state selection, wake-up, clock switching and watchdog control for a small MCU core.
// Assumes an APB master on pclk; pins, oscillator stable and low-osc tick arrive asynchronous.
`timescale 1ns/1ps
module hww_ctrl
  import hww_pkg::*;
#(
  parameter int PINS = 8,
  parameter int SW_RESET_CYC = HWW_SW_RESET_CYC
)
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [PINS-1:0] porta_pin,
  input wire logic fast_osc_ready,
  input wire logic low_osc_tick,
  input wire logic irq_req,
  input wire logic irq_enabled,
  input wire logic stack_full,
  output logic fast_clk_en,
  output logic slow_clk_en,
  output logic cpu_run,
  output logic [2:0] sysclk_div_sel,
  output logic irq_take,
  output logic pc_sp_reset,
  output logic wdt_reset_req
);

  initial
  begin
    if (PINS < 1 || PINS > 8) $error("hww_ctrl: PINS must be 1 to 8");
    if (SW_RESET_CYC < 1) $error("hww_ctrl: SW_RESET_CYC must be positive");
  end

  ////////////////////////////////////////////////////////////////////////////////
  // State

  typedef struct packed {
    hww_mode_t mode;
    logic [2:0] div_sel;
    logic [2:0] div_pending;
    logic fast_keep;
    logic slow_keep;
    logic fast_osc_ctrl;
    logic [7:0] wdt_ctrl;
    logic [7:0] wake_en;
    logic powerdown_flag;
    logic wdt_timeout_flag;
    logic wdt_key_reset_flag;
    logic irq_masked;
    logic [31:0] key_cnt;
    logic key_bad;
    logic [PINS-1:0] pin_s1;
    logic [PINS-1:0] pin_s2;
    logic [PINS-1:0] pin_d;
    logic [2:0] rdy_s;
    logic [31:0] rdata;
    logic ready;
    logic slverr;
    hww_clk_t clk;
    logic irq_take;
    logic pc_sp_reset;
    logic wdt_reset_req;
  } hww_state_t;

  hww_state_t s_r;
  hww_state_t s_nxt;

  logic wdt_clear;
  logic wdt_ovf;
  logic tick_s1_r;
  logic tick_s2_r;
  logic tick_d_r;

  function automatic logic hww_key_ok(input logic [7:0] ctrl);
    hww_key_ok = (ctrl[HWW_KEY_LSB +: 5] == HWW_KEY_A) || (ctrl[HWW_KEY_LSB +: 5] == HWW_KEY_B);
  endfunction : hww_key_ok

  function automatic logic hww_halted(input hww_mode_t m);
    hww_halted = (m != HWW_RUN);
  endfunction : hww_halted

  ////////////////////////////////////////////////////////////////////////////////
  // Low-speed tick crossing; edge taken on second stage only

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      tick_s1_r <= 1'b0;
      tick_s2_r <= 1'b0;
      tick_d_r <= 1'b0;
    end
    else
    begin
      tick_s1_r <= low_osc_tick;
      tick_s2_r <= tick_s1_r;
      tick_d_r <= tick_s2_r;
    end
  end

  hww_wdt_counter #(
    .WIDTH(HWW_WDT_W)
  ) u_wdt (
    .pclk(pclk),
    .presetn(presetn),
    .tick(tick_s2_r && !tick_d_r),
    .clear(wdt_clear),
    .period_sel(s_r.wdt_ctrl[HWW_KEY_LSB-1:0]),
    .overflow(wdt_ovf)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Next state

  logic wr;
  logic rd;
  logic halt_cmd;
  logic clr_cmd;
  logic pin_wake;
  logic irq_wake;
  logic halted;

  always_comb
  begin
    s_nxt = s_r;
    wr = psel && penable && pwrite && !s_r.ready;
    rd = psel && penable && !pwrite && !s_r.ready;
    halt_cmd = wr && (paddr == HWW_ADDR_CMD) && pwdata[HWW_CMD_HALT];
    clr_cmd = wr && (paddr == HWW_ADDR_CMD) && pwdata[HWW_CMD_CLRWDT];
    halted = hww_halted(s_r.mode);
    s_nxt.irq_take = 1'b0;
    s_nxt.pc_sp_reset = 1'b0;
    s_nxt.ready = psel && penable && !s_r.ready;
    s_nxt.slverr = 1'b0;

    // Pin and oscillator-ready synchronisers
    s_nxt.pin_s1 = porta_pin;
    s_nxt.pin_s2 = s_r.pin_s1;
    s_nxt.pin_d = s_r.pin_s2;
    s_nxt.rdy_s[1] = fast_osc_ready;
    s_nxt.rdy_s[2] = s_r.rdy_s[1];
    s_nxt.rdy_s[0] = 1'b0;

    pin_wake = |(s_r.pin_d & ~s_r.pin_s2 & s_r.wake_en[PINS-1:0]);
    irq_wake = irq_req && !s_r.irq_masked;
    // Halt and clear instruction are the only external counter clears; the counter also returns to zero on its own overflow
    wdt_clear = halt_cmd || clr_cmd;

    // Register writes; halting leaves the written registers alone and changes only the STATUS flags
    if (wr)
    begin
      case (paddr)
        HWW_ADDR_CLK_CTRL:
        begin
          s_nxt.div_pending = pwdata[HWW_DIV_LSB +: 3];
          s_nxt.fast_keep = pwdata[HWW_FAST_KEEP_BIT];
          s_nxt.slow_keep = pwdata[HWW_SLOW_KEEP_BIT];
        end
        HWW_ADDR_OSC_CTRL: s_nxt.fast_osc_ctrl = pwdata[HWW_OSC_EN_BIT];
        HWW_ADDR_WDT: s_nxt.wdt_ctrl = pwdata[7:0];
        HWW_ADDR_RST_FLAG: if (!pwdata[HWW_KEY_FLAG_BIT]) s_nxt.wdt_key_reset_flag = 1'b0;
        HWW_ADDR_WAKE_EN: s_nxt.wake_en = pwdata[7:0];
        HWW_ADDR_CMD: ;
        default: s_nxt.slverr = 1'b1;
      endcase
    end

    // Clock divide: leave slow only once the fast oscillator is stable
    if (s_nxt.div_pending == HWW_DIV_SLOW)
      s_nxt.div_sel = HWW_DIV_SLOW;
    else if (s_r.div_sel != HWW_DIV_SLOW || s_r.rdy_s[2])
      s_nxt.div_sel = s_nxt.div_pending;

    if (clr_cmd)
      s_nxt.powerdown_flag = 1'b0;

    // Halt entry
    if (halt_cmd && !halted)
    begin
      case ({s_r.fast_keep, s_r.slow_keep})
        2'b00: s_nxt.mode = HWW_SLEEP;
        2'b01: s_nxt.mode = HWW_HALT_SLOW_ONLY;
        2'b11: s_nxt.mode = HWW_HALT_BOTH_CLOCKS;
        default: s_nxt.mode = HWW_HALT_FAST_ONLY;
      endcase
      s_nxt.powerdown_flag = 1'b1;
      s_nxt.wdt_timeout_flag = 1'b0;
      s_nxt.irq_masked = irq_req;
    end
    else if (halted && (pin_wake || irq_wake || wdt_ovf))
    begin
      s_nxt.mode = HWW_RUN;
      if (wdt_ovf)
      begin
        s_nxt.wdt_timeout_flag = 1'b1;
        s_nxt.pc_sp_reset = 1'b1;
      end
      else if (irq_wake)
        s_nxt.irq_take = irq_enabled && !stack_full;
    end

    // Key check: bad key counts the reset delay then requests reset
    s_nxt.key_bad = !hww_key_ok(s_r.wdt_ctrl);
    if (s_r.key_bad && !s_r.wdt_reset_req)
    begin
      if (s_r.key_cnt >= 32'(SW_RESET_CYC - 1))
      begin
        s_nxt.wdt_reset_req = 1'b1;
        s_nxt.wdt_key_reset_flag = 1'b1;
      end
      else
        s_nxt.key_cnt = s_r.key_cnt + 32'h1;
    end
    else if (!s_r.key_bad)
      s_nxt.key_cnt = '0;
    // Overflow while running is a full reset request; the flag needs the timeout too
    if (!halted && wdt_ovf)
    begin
      s_nxt.wdt_reset_req = 1'b1;
      s_nxt.wdt_timeout_flag = 1'b1;
    end

    // Clock enables follow the mode
    case (s_nxt.mode)
      HWW_RUN: s_nxt.clk = '{1'b1, 1'b1, 1'b1, s_nxt.div_sel};
      HWW_SLEEP: s_nxt.clk = '{1'b0, 1'b0, 1'b0, s_nxt.div_sel};
      HWW_HALT_SLOW_ONLY: s_nxt.clk = '{1'b0, 1'b1, 1'b0, s_nxt.div_sel};
      HWW_HALT_BOTH_CLOCKS: s_nxt.clk = '{1'b1, 1'b1, 1'b0, s_nxt.div_sel};
      HWW_HALT_FAST_ONLY: s_nxt.clk = '{1'b1, 1'b0, 1'b0, s_nxt.div_sel};
      default: s_nxt.clk = '{1'b1, 1'b1, 1'b1, s_nxt.div_sel};
    endcase
    if (s_nxt.mode == HWW_RUN && s_nxt.div_sel == HWW_DIV_SLOW && !s_nxt.fast_osc_ctrl)
      s_nxt.clk.fast_clk_en = 1'b0;

    // Read data, captured in the single access cycle
    s_nxt.rdata = '0;
    if (rd)
    begin
      case (paddr)
        HWW_ADDR_CLK_CTRL:
          s_nxt.rdata[7:0] = {s_r.div_pending, 3'h0, s_r.fast_keep, s_r.slow_keep};
        HWW_ADDR_OSC_CTRL: s_nxt.rdata[7:0] = {6'h00, s_r.rdy_s[2], s_r.fast_osc_ctrl};
        HWW_ADDR_WDT: s_nxt.rdata[7:0] = s_r.wdt_ctrl;
        HWW_ADDR_RST_FLAG: s_nxt.rdata[7:0] = {7'h00, s_r.wdt_key_reset_flag};
        HWW_ADDR_STATUS:
          s_nxt.rdata[7:0] = {4'h0, s_r.div_sel == HWW_DIV_SLOW, halted,
                              s_r.wdt_timeout_flag, s_r.powerdown_flag};
        HWW_ADDR_WAKE_EN: s_nxt.rdata[7:0] = s_r.wake_en;
        HWW_ADDR_CMD: s_nxt.rdata = '0;
        default: s_nxt.slverr = 1'b1;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Registers

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      s_r <= '0;
      s_r.mode <= HWW_RUN;
      s_r.div_sel <= HWW_CLK_CTRL_RST[HWW_DIV_LSB +: 3];
      s_r.div_pending <= HWW_CLK_CTRL_RST[HWW_DIV_LSB +: 3];
      s_r.fast_osc_ctrl <= HWW_OSC_CTRL_RST[HWW_OSC_EN_BIT];
      s_r.wdt_ctrl <= HWW_WDT_RST;
      s_r.wake_en <= HWW_WAKE_EN_RST;
      s_r.clk <= '{1'b1, 1'b1, 1'b1, HWW_CLK_CTRL_RST[HWW_DIV_LSB +: 3]};
    end
    else
      s_r <= s_nxt;
  end

  assign prdata = s_r.rdata;
  assign pready = s_r.ready;
  assign pslverr = s_r.slverr;
  assign fast_clk_en = s_r.clk.fast_clk_en;
  assign slow_clk_en = s_r.clk.slow_clk_en;
  assign cpu_run = s_r.clk.cpu_run;
  assign sysclk_div_sel = s_r.clk.div_sel;
  assign irq_take = s_r.irq_take;
  assign pc_sp_reset = s_r.pc_sp_reset;
  assign wdt_reset_req = s_r.wdt_reset_req;

endmodule : hww_ctrl

// *** common/hww_pkg.sv ***
// Package for the halt, wake-up and watchdog block: register map, fields, modes, timing.
// Assumes an APB slave with 32-bit data; every register sits in the low byte of a word.
package hww_pkg;

  localparam logic [7:0] HWW_ADDR_CLK_CTRL = 8'h00;
  localparam logic [7:0] HWW_ADDR_OSC_CTRL = 8'h04;
  localparam logic [7:0] HWW_ADDR_WDT = 8'h08;
  localparam logic [7:0] HWW_ADDR_RST_FLAG = 8'h0C;
  localparam logic [7:0] HWW_ADDR_STATUS = 8'h10;
  localparam logic [7:0] HWW_ADDR_WAKE_EN = 8'h14;
  localparam logic [7:0] HWW_ADDR_CMD = 8'h18;

  // Clock control comes out of reset on the undivided fast clock
  localparam logic [7:0] HWW_CLK_CTRL_RST = 8'h00;
  localparam logic [7:0] HWW_OSC_CTRL_RST = 8'h01;
  localparam logic [7:0] HWW_WDT_RST = 8'h53;
  localparam logic [7:0] HWW_WAKE_EN_RST = 8'h00;

  // Field positions
  localparam int HWW_DIV_LSB = 5;
  localparam int HWW_FAST_KEEP_BIT = 1;
  localparam int HWW_SLOW_KEEP_BIT = 0;
  localparam int HWW_OSC_EN_BIT = 0;
  localparam int HWW_KEY_LSB = 3;
  localparam int HWW_KEY_FLAG_BIT = 0;

  localparam logic [2:0] HWW_DIV_SLOW = 3'h7;
  localparam logic [4:0] HWW_KEY_A = 5'h0A;
  localparam logic [4:0] HWW_KEY_B = 5'h15;

  // Command register bits
  localparam int HWW_CMD_HALT = 0;
  localparam int HWW_CMD_CLRWDT = 1;

  // Software reset delay, in ns, and its cycle count at 100 MHz
  localparam int HWW_CLK_NS = 10;
  localparam int HWW_SW_RESET_NS = 16000;
  localparam int HWW_SW_RESET_CYC = (HWW_SW_RESET_NS + HWW_CLK_NS - 1) / HWW_CLK_NS;

  localparam int HWW_WDT_W = 18;
  // Watchdog terminal bit per period code; code 7 is the longest ratio
  localparam int HWW_WDT_TAP [8] = '{8, 10, 12, 14, 15, 16, 17, 18};

  typedef enum logic [2:0] {
    HWW_RUN,
    HWW_SLEEP,
    HWW_HALT_SLOW_ONLY,
    HWW_HALT_BOTH_CLOCKS,
    HWW_HALT_FAST_ONLY
  } hww_mode_t;

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata;
  } hww_apb_req_t;

  typedef struct packed {
    logic fast_clk_en;
    logic slow_clk_en;
    logic cpu_run;
    logic [2:0] div_sel;
  } hww_clk_t;

endpackage : hww_pkg

// *** src/hww_wdt_counter.sv ***
// Watchdog counter stepped by ticks of the low-speed oscillator.
// Assumes the tick is a one-cycle pulse already synchronised into pclk.
`timescale 1ns/1ps
module hww_wdt_counter
  import hww_pkg::*;
#(
  parameter int WIDTH = HWW_WDT_W
)
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic tick,
  input wire logic clear,
  input wire logic [2:0] period_sel,
  output logic overflow
);

  initial
  begin
    if (WIDTH < HWW_WDT_TAP[7]) $error("hww_wdt_counter: WIDTH too small for longest period");
  end

  logic [WIDTH-1:0] cnt_r;
  logic [WIDTH-1:0] cnt_nxt;
  logic hit;

  // Terminal bit for each period code; code 7 gives the longest ratio
  function automatic int hww_tap(input logic [2:0] sel);
    hww_tap = HWW_WDT_TAP[sel];
  endfunction : hww_tap

  always_comb
  begin
    hit = tick && (cnt_r == WIDTH'((64'h1 << hww_tap(period_sel)) - 64'h1));
    if (clear || hit)
      cnt_nxt = '0;
    else if (tick)
      cnt_nxt = cnt_r + WIDTH'(1);
    else
      cnt_nxt = cnt_r;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cnt_r <= '0;
      overflow <= 1'b0;
    end
    else
    begin
      cnt_r <= cnt_nxt;
      overflow <= hit && !clear;
    end
  end

endmodule : hww_wdt_counter

// *** test/hww_ctrl_assertions.sv ***
// Port checks for the halt, wake-up and watchdog control block.
// Assumes it is bound onto hww_ctrl and sees its ports only.
`timescale 1ns/1ps
module hww_ctrl_assertions
  import hww_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic fast_osc_ready,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic cpu_run,
  input wire logic [2:0] sysclk_div_sel,
  input wire logic irq_take,
  input wire logic pc_sp_reset
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  ////////////////////////////////////////
  ready_pulse_a: assert property (pready |=> !pready)
    else $error("pready too long");
  ready_answer_a: assert property (psel && penable && !pready |=> pready)
    else $error("no answer");
  err_ready_a: assert property (pslverr |-> pready)
    else $error("pslverr alone");
  irq_wake_a: assert property (irq_take |-> !$past(cpu_run)
    ##1 !irq_take && cpu_run)
    else $error("irq_take bad");
  wdt_wake_a: assert property (pc_sp_reset |-> !$past(cpu_run)
    ##1 !pc_sp_reset && cpu_run)
    else $error("pc_sp_reset bad");
  // Two sync stages plus the switching edge lie between the flag pin and the divider output
  div_wait_a: assert property ($past(sysclk_div_sel) == HWW_DIV_SLOW &&
    sysclk_div_sel != HWW_DIV_SLOW |-> $past(fast_osc_ready, 3))
    else $error("fast before stable");
  halt_hold_a: assert property (!cpu_run && !$past(cpu_run) |-> $stable(sysclk_div_sel))
    else $error("divider moved");
  halt_cause_a: assert property ($fell(cpu_run) |-> $past(psel && pwrite))
    else $error("halt without write");
endmodule : hww_ctrl_assertions

bind hww_ctrl hww_ctrl_assertions i_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .fast_osc_ready(fast_osc_ready), .pready(pready),
  .pslverr(pslverr), .cpu_run(cpu_run), .sysclk_div_sel(sysclk_div_sel),
  .irq_take(irq_take), .pc_sp_reset(pc_sp_reset));

// *** test/hww_far_model.sv ***
// Far-side model: low-speed oscillator and fast oscillator start-up.
// Assumes osc_on from the bench stands for the fast oscillator power.
`timescale 1ns/1ps
module hww_far_model
#(
  parameter int HALF = 4,
  parameter int SETTLE = 20
)
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic osc_on,
  output logic low_osc_tick,
  output logic fast_osc_ready
);
  int ph = 0;
  int st = 0;
  logic tk = 0;
  assign low_osc_tick = tk;
  assign fast_osc_ready = (st >= SETTLE);
  ////////////////////////////////////////
  // Free running, since the watchdog keeps this oscillator alive
  always @(posedge pclk)
  begin
    ph <= (ph + 1) % (2 * HALF);
    tk <= (ph < HALF);
  end
  // Flag stays low until a restart has settled
  always @(posedge pclk)
  begin
    if (!presetn || !osc_on)
      st <= 0;
    else if (st < SETTLE)
      st <= st + 1;
  end
endmodule : hww_far_model

// *** test/test_halt_wakeup_watchdog.sv ***
// Self-checking bench for the halt, wake-up and watchdog block.
// Assumes hww_ctrl and hww_far_model; plays APB master, pins and interrupt.
`timescale 1ns/1ps
module test_halt_wakeup_watchdog;
  import hww_pkg::*;
  logic pclk = 0;
  logic presetn = 0;
  logic psel = 0;
  logic penable = 0;
  logic pwrite = 0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [7:0] pins = 8'hFF;
  logic osc_on = 1;
  logic irq_req = 0;
  logic irq_en = 0;
  logic stack_full = 0;
  logic [31:0] prdata, r;
  logic [2:0] div;
  logic pready, pslverr, fce, sce, cpu_run, irq_take, pcs, wrq, tick, rdy, e;
  int err_count = 0;
  int checked = 0;
  int takes = 0;
  int pcsp = 0;
  int n;
  // Keep bits, then the fast and slow enables they should leave
  logic [3:0] rows [4] = '{4'h0, 4'h5, 4'hF, 4'hA};
  always #5 pclk = ~pclk;
  always @(posedge pclk)
  begin
    takes <= takes + 32'(irq_take === 1'b1);
    pcsp <= pcsp + 32'(pcs === 1'b1);
  end
  hww_far_model i_far (.pclk(pclk), .presetn(presetn), .osc_on(osc_on),
    .low_osc_tick(tick), .fast_osc_ready(rdy));
  hww_ctrl #(.PINS(8), .SW_RESET_CYC(8)) i_dut (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .porta_pin(pins),
    .fast_osc_ready(rdy), .low_osc_tick(tick), .irq_req(irq_req), .irq_enabled(irq_en),
    .stack_full(stack_full), .fast_clk_en(fce), .slow_clk_en(sce), .cpu_run(cpu_run),
    .sysclk_div_sel(div), .irq_take(irq_take), .pc_sp_reset(pcs), .wdt_reset_req(wrq));
  ////////////////////////////////////////
  task automatic chk(input string s, input logic [31:0] x, input logic [31:0] g);
    checked++;
    if (g !== x)
    begin
      err_count++;
      $display("wrong value %s exp %h got %h", s, x, g);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1;
    penable <= 0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    do
      @(posedge pclk);
    while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 0;
    penable <= 0;
  endtask : apb
  task automatic rst();
    presetn <= 0;
    repeat (8) @(posedge pclk);
    presetn <= 1;
  endtask : rst
  task automatic hlt();
    apb(1, HWW_ADDR_CMD, 32'h1);
    repeat (3) @(posedge pclk);
  endtask : hlt
  task automatic wk(input int lim);
    for (n = 0; n < lim && cpu_run !== 1'b1; n++)
      @(posedge pclk);
    // One more edge so the pulse counters have taken the wake pulses
    @(posedge pclk);
    chk("wake", 1, 32'(cpu_run));
  endtask : wk
  task automatic final_report();
    $display("checks %0d mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : final_report
  ////////////////////////////////////////
  initial
  begin
    repeat (40000) @(posedge pclk);
    err_count++;
    final_report();
  end
  initial
  begin
    rst();
    apb(0, HWW_ADDR_CLK_CTRL, 0);
    chk("clk ctrl", 32'(HWW_CLK_CTRL_RST), r);
    apb(0, HWW_ADDR_WDT, 0);
    chk("wdt", 32'(HWW_WDT_RST), r);
    apb(0, 8'h1C, 0);
    chk("unmapped", 32'h1, 32'(e));
    chk("unmapped data", 32'h0, r);
    $display("end reset");
    for (int i = 0; i < 4; i++)
    begin
      apb(1, HWW_ADDR_WAKE_EN, 32'h1);
      apb(1, HWW_ADDR_CLK_CTRL, {24'h0, 6'h38, rows[i][3:2]});
      hlt();
      chk("clocks", 32'(rows[i][1:0]), 32'({fce, sce}));
      apb(0, HWW_ADDR_STATUS, 0);
      chk("halt status", 32'h0D, r);
      pins[0] <= 0;
      wk(20);
      pins[0] <= 1;
      apb(0, HWW_ADDR_CLK_CTRL, 0);
      chk("kept", {24'h0, 6'h38, rows[i][3:2]}, r);
      apb(0, HWW_ADDR_STATUS, 0);
      chk("woken", 32'h09, r);
      apb(1, HWW_ADDR_CMD, 32'h2);
      apb(0, HWW_ADDR_STATUS, 0);
      chk("cleared", 32'h08, r);
    end
    $display("end halt rows");
    osc_on <= 0;
    // Let the dropped stable flag pass the synchroniser before asking for fast
    repeat (4) @(posedge pclk);
    apb(1, HWW_ADDR_CLK_CTRL, 32'h60);
    repeat (20) @(posedge pclk);
    chk("div held", 32'(HWW_DIV_SLOW), 32'(div));
    apb(0, HWW_ADDR_OSC_CTRL, 0);
    chk("osc flag low", 32'h1, r);
    osc_on <= 1;
    for (int c = 0; c < 7; c++)
    begin
      apb(1, HWW_ADDR_CLK_CTRL, 32'hE0);
      apb(1, HWW_ADDR_CLK_CTRL, {24'h0, 3'(c), 5'h0});
      repeat (30) @(posedge pclk);
      chk("div", 32'(c), 32'(div));
    end
    apb(0, HWW_ADDR_OSC_CTRL, 0);
    chk("osc flag high", 32'h3, r);
    $display("end clock switch");
    apb(1, HWW_ADDR_WAKE_EN, 32'h2);
    hlt();
    pins[0] <= 0;
    repeat (20) @(posedge pclk);
    chk("masked pin", 0, 32'(cpu_run));
    pins[1] <= 0;
    wk(20);
    pins <= 8'hFF;
    irq_en <= 1;
    hlt();
    irq_req <= 1;
    wk(20);
    chk("taken", 1, 32'(takes));
    for (int k = 0; k < 2; k++)
    begin
      irq_req <= 0;
      irq_en <= k[0];
      stack_full <= k[0];
      hlt();
      irq_req <= 1;
      wk(20);
      chk("deferred", 1, 32'(takes));
    end
    hlt();
    repeat (20) @(posedge pclk);
    chk("pending", 0, 32'(cpu_run));
    irq_req <= 0;
    pins[1] <= 0;
    wk(20);
    pins <= 8'hFF;
    $display("end wake sources");
    apb(1, HWW_ADDR_CMD, 32'h2);
    apb(1, HWW_ADDR_WDT, 32'h50);
    repeat (1200) @(posedge pclk);
    hlt();
    repeat (1200) @(posedge pclk);
    chk("still asleep", 0, 32'(cpu_run));
    wk(2000);
    chk("pc sp", 1, 32'(pcsp));
    apb(0, HWW_ADDR_STATUS, 0);
    chk("timeout", 32'h03, r);
    for (n = 0; n < 3000 && wrq !== 1'b1; n++)
      @(posedge pclk);
    chk("run overflow", 1, 32'(wrq));
    $display("end overflow");
    rst();
    apb(1, HWW_ADDR_WDT, 32'hAB);
    repeat (20) @(posedge pclk);
    chk("key b", 0, 32'(wrq));
    apb(1, HWW_ADDR_WDT, 32'h03);
    chk("early", 0, 32'(wrq));
    repeat (20) @(posedge pclk);
    chk("bad key", 1, 32'(wrq));
    apb(0, HWW_ADDR_RST_FLAG, 0);
    chk("key flag", 32'h1, r);
    $display("end key");
    final_report();
  end
endmodule : test_halt_wakeup_watchdog
